// *** core/uart_timer_pkg.sv ***
// constants and types shared by the uart timer pair control block
package uart_timer_pkg;

  // --------------------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // --------------------------------------------------------------------------
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_MODE     = 8'h04;
  localparam logic [7:0]  OFS_GT_CNT   = 8'h08;
  localparam logic [7:0]  OFS_BRG_CNT  = 8'h0C;
  localparam logic [7:0]  OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0]  OFS_IRQ_MASK = 8'h14;

  // --------------------------------------------------------------------------
  // control/status fields
  // --------------------------------------------------------------------------
  localparam int          BIT_BAUD_DOUBLE = 7;
  localparam int          BIT_RSVD        = 6;
  localparam int          BIT_BRG_CLK_SEL = 5;
  localparam int          BIT_GT_CLK_SEL  = 4;
  localparam int          BIT_BRG_OVF     = 3;
  localparam int          BIT_GT_OVF      = 2;
  localparam int          BIT_BRG_RUN     = 1;
  localparam int          BIT_GT_RUN      = 0;
  localparam logic [7:0]  CTRL_WR_MASK    = 8'hBF;

  // --------------------------------------------------------------------------
  // mode fields
  // --------------------------------------------------------------------------
  localparam int          BIT_BRG_GATE    = 7;
  localparam int          BIT_BRG_CNT_SEL = 6;
  localparam int          BIT_BRG_MODE_HI = 5;
  localparam int          BIT_BRG_MODE_LO = 4;
  localparam int          BIT_GT_GATE     = 3;
  localparam int          BIT_GT_CNT_SEL  = 2;
  localparam int          BIT_GT_MODE_HI  = 1;
  localparam int          BIT_GT_MODE_LO  = 0;

  // --------------------------------------------------------------------------
  // reset values and timing
  // --------------------------------------------------------------------------
  localparam logic [7:0]  RST_CTRL     = 8'h00;
  localparam logic [7:0]  RST_MODE     = 8'h00;
  localparam logic [15:0] RST_CNT      = 16'h0000;
  localparam logic        RST_IRQ      = 1'b0;
  localparam logic [3:0]  PRESCALE_DIV = 4'hC;
  localparam logic [4:0]  LO13_MAX     = 5'h1F;

  typedef enum logic [1:0] {
    TMR_13BIT       = 2'h0,
    TMR_16BIT       = 2'h1,
    TMR_8BIT_RELOAD = 2'h2,
    TMR_SPLIT       = 2'h3
  } timer_mode_t;

endpackage

// *** core/uart_timer_pair_control.sv ***
// uart timer pair: general timer and baud rate generator with wishbone registers
// Summary of operation
// - baud_double set doubles the uart baud rate
// - brg counts on clk/12 or clk
// - general timer counts on clk/12 or clk
// - brg overflow sets flag, never interrupts
// - timer overflow sets flag and may interrupt
// - brg counts only while its run bit set
// - general timer counts only while run set
// - brg mode: 13, 16, 8-reload, split
// - timer mode: 13, 16, 8-reload, split
// - timer flag cleared on service acknowledge
// - uart bit rate from brg overflows
`timescale 1ns/10ps
`default_nettype none

module uart_timer_pair_control (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // cpu interrupt
  input  wire logic        isr_ack,
  output logic             irq,
  // serial engine
  output logic             baud_double,
  output logic             brg_tick
);

  // --------------------------------------------------------------------------
  // reset release
  // --------------------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_n;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_ff <= 1'b0;
      rst_n       <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n       <= rst_meta_ff;
    end
  end

  // --------------------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------------------
  logic        ack_ff;
  logic [31:0] rdat_ff;
  logic [7:0]  uart_timer_control_status_ff;
  logic [7:0]  uart_timer_mode_control_ff;
  logic [15:0] cnt_ff [2];
  logic        irq_stat_ff;
  logic        irq_mask_ff;

  wire       req     = wb_cyc_i & wb_stb_i;
  wire       wr_now  = req & wb_we_i & ack_ff;
  wire       hit_ctl = wb_adr_i == uart_timer_pkg::OFS_CTRL;
  wire       hit_mod = wb_adr_i == uart_timer_pkg::OFS_MODE;
  wire       hit_gtc = wb_adr_i == uart_timer_pkg::OFS_GT_CNT;
  wire       hit_brc = wb_adr_i == uart_timer_pkg::OFS_BRG_CNT;
  wire       hit_ist = wb_adr_i == uart_timer_pkg::OFS_IRQ_STAT;
  wire       hit_imk = wb_adr_i == uart_timer_pkg::OFS_IRQ_MASK;
  wire       ctrl_wr = wr_now & hit_ctl & wb_sel_i[0];
  wire       mode_wr = wr_now & hit_mod & wb_sel_i[0];
  wire       stat_wr = wr_now & hit_ist & wb_sel_i[0];
  wire       mask_wr = wr_now & hit_imk & wb_sel_i[0];
  wire [1:0] cnt_wr  = {wr_now & hit_brc & (|wb_sel_i[1:0]), wr_now & hit_gtc & (|wb_sel_i[1:0])};

  wire [31:0] rd_mux =
    hit_ctl ? {24'h000000, uart_timer_control_status_ff} :
    hit_mod ? {24'h000000, uart_timer_mode_control_ff} :
    hit_gtc ? {16'h0000, cnt_ff[0]} :
    hit_brc ? {16'h0000, cnt_ff[1]} :
    hit_ist ? {31'h00000000, irq_stat_ff} :
    hit_imk ? {31'h00000000, irq_mask_ff} : 32'h00000000;

  // ack one cycle after the request, then drop for a cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h00000000;
    end else begin
      ack_ff  <= req & ~ack_ff;
      rdat_ff <= (req & ~ack_ff) ? rd_mux : rdat_ff;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  a_bus_ack_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    req && !ack_ff |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle after request");

  // --------------------------------------------------------------------------
  // clk/12 prescaler
  // --------------------------------------------------------------------------
  logic [3:0] pre_cnt_ff;
  wire        pre_tick = pre_cnt_ff == (uart_timer_pkg::PRESCALE_DIV - 4'h1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt_ff <= 4'h0;
    end else begin
      pre_cnt_ff <= pre_tick ? 4'h0 : pre_cnt_ff + 4'h1;
    end
  end

  // --------------------------------------------------------------------------
  // timer stepping, index 0 general timer, index 1 baud rate generator
  // --------------------------------------------------------------------------
  function automatic logic [16:0] step(input logic [1:0] mode, input logic [15:0] c);
    logic [7:0]  hi;
    logic [7:0]  lo;
    logic [16:0] r;
    hi = c[15:8];
    lo = c[7:0];
    r  = {1'b0, c};
    unique case (mode)
      uart_timer_pkg::TMR_13BIT: begin
        r[16]  = (hi == 8'hFF) && (lo[4:0] == uart_timer_pkg::LO13_MAX);
        r[4:0] = lo[4:0] + 5'h01;
        if (lo[4:0] == uart_timer_pkg::LO13_MAX) begin
          r[15:8] = hi + 8'h01;
        end
      end
      uart_timer_pkg::TMR_16BIT: begin
        r = {1'b0, c} + 17'h00001;
      end
      uart_timer_pkg::TMR_8BIT_RELOAD: begin
        r[16]  = lo == 8'hFF;
        r[7:0] = (lo == 8'hFF) ? hi : lo + 8'h01;
      end
      uart_timer_pkg::TMR_SPLIT: begin
        // both halves count; only the low half reports overflow
        r[16]   = lo == 8'hFF;
        r[7:0]  = lo + 8'h01;
        r[15:8] = hi + 8'h01;
      end
    endcase
    return r;
  endfunction

  // gate and count-select bits are stored only: running follows the run bit
  // alone and the clock the clock-select bit alone
  wire [1:0] tmr_run  = {uart_timer_control_status_ff[uart_timer_pkg::BIT_BRG_RUN],
                         uart_timer_control_status_ff[uart_timer_pkg::BIT_GT_RUN]};
  wire [1:0] tmr_fast = {uart_timer_control_status_ff[uart_timer_pkg::BIT_BRG_CLK_SEL],
                         uart_timer_control_status_ff[uart_timer_pkg::BIT_GT_CLK_SEL]};
  wire [1:0] tmr_mode [2];
  wire [1:0] ovf;
  wire [1:0] tick;

  assign tmr_mode[0] = {uart_timer_mode_control_ff[uart_timer_pkg::BIT_GT_MODE_HI],
                        uart_timer_mode_control_ff[uart_timer_pkg::BIT_GT_MODE_LO]};
  assign tmr_mode[1] = {uart_timer_mode_control_ff[uart_timer_pkg::BIT_BRG_MODE_HI],
                        uart_timer_mode_control_ff[uart_timer_pkg::BIT_BRG_MODE_LO]};

  for (genvar i = 0; i < 2; i++) begin : g_tmr
    wire [16:0] stepped = step(tmr_mode[i], cnt_ff[i]);
    wire [15:0] wr_val  = {wb_sel_i[1] ? wb_dat_i[15:8] : cnt_ff[i][15:8],
                           wb_sel_i[0] ? wb_dat_i[7:0] : cnt_ff[i][7:0]};
    assign tick[i] = tmr_run[i] & (tmr_fast[i] | pre_tick);
    assign ovf[i]  = tick[i] & stepped[16];

    // a software load wins over a count in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        cnt_ff[i] <= uart_timer_pkg::RST_CNT;
      end else if (cnt_wr[i]) begin
        cnt_ff[i] <= wr_val;
      end else if (tick[i]) begin
        cnt_ff[i] <= stepped[15:0];
      end
    end

    a_run_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !tmr_run[i] && !cnt_wr[i] |=> $stable(cnt_ff[i]))
      else $error("stopped timer changed its count");
    a_slow_clock: assert property (@(posedge clk) disable iff (!rst_n)
      !tmr_fast[i] && !pre_tick && !cnt_wr[i] |=> $stable(cnt_ff[i]))
      else $error("timer counted between prescaler ticks");
    // an all-ones reload value reloads onto itself, so that one case is left out
    a_fast_clock: assert property (@(posedge clk) disable iff (!rst_n)
      tmr_fast[i] && tmr_run[i] && !cnt_wr[i]
      && !(tmr_mode[i] == uart_timer_pkg::TMR_8BIT_RELOAD && cnt_ff[i] == 16'hFFFF)
      |=> cnt_ff[i] != $past(cnt_ff[i]))
      else $error("timer on fast clock missed a cycle");
    a_reload_low: assert property (@(posedge clk) disable iff (!rst_n)
      ovf[i] && tmr_mode[i] == uart_timer_pkg::TMR_8BIT_RELOAD && !cnt_wr[i]
      |=> cnt_ff[i][7:0] == $past(cnt_ff[i][15:8]) && $stable(cnt_ff[i][15:8]))
      else $error("auto-reload did not copy high byte");
    a_wrap_13bit: assert property (@(posedge clk) disable iff (!rst_n)
      ovf[i] && tmr_mode[i] == uart_timer_pkg::TMR_13BIT && !cnt_wr[i]
      |=> cnt_ff[i][15:8] == 8'h00 && cnt_ff[i][4:0] == 5'h00)
      else $error("13-bit timer did not wrap to zero");
    a_wrap_16bit: assert property (@(posedge clk) disable iff (!rst_n)
      ovf[i] && tmr_mode[i] == uart_timer_pkg::TMR_16BIT && !cnt_wr[i]
      |=> cnt_ff[i] == 16'h0000)
      else $error("16-bit timer did not wrap to zero");
    a_split_high: assert property (@(posedge clk) disable iff (!rst_n)
      tick[i] && tmr_mode[i] == uart_timer_pkg::TMR_SPLIT && !cnt_wr[i]
      |=> cnt_ff[i][15:8] == $past(cnt_ff[i][15:8]) + 8'h01)
      else $error("split timer high half did not count");
  end

  // --------------------------------------------------------------------------
  // control/status and mode registers
  // --------------------------------------------------------------------------
  logic [7:0] nxt_ctrl;

  // hardware set wins over a software write or a service clear
  always_comb begin
    nxt_ctrl = ctrl_wr ? (wb_dat_i[7:0] & uart_timer_pkg::CTRL_WR_MASK) : uart_timer_control_status_ff;
    if (isr_ack) begin
      nxt_ctrl[uart_timer_pkg::BIT_GT_OVF] = 1'b0;
    end
    if (ovf[0]) begin
      nxt_ctrl[uart_timer_pkg::BIT_GT_OVF] = 1'b1;
    end
    if (ovf[1]) begin
      nxt_ctrl[uart_timer_pkg::BIT_BRG_OVF] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      uart_timer_control_status_ff <= uart_timer_pkg::RST_CTRL;
      uart_timer_mode_control_ff   <= uart_timer_pkg::RST_MODE;
    end else begin
      uart_timer_control_status_ff <= nxt_ctrl;
      uart_timer_mode_control_ff   <= mode_wr ? wb_dat_i[7:0] : uart_timer_mode_control_ff;
    end
  end

  assign baud_double = uart_timer_control_status_ff[uart_timer_pkg::BIT_BAUD_DOUBLE];

  a_baud_double: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl_wr |=> baud_double == $past(wb_dat_i[uart_timer_pkg::BIT_BAUD_DOUBLE]))
    else $error("baud double does not follow write");
  a_rsvd_zero: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl_wr |=> !uart_timer_control_status_ff[uart_timer_pkg::BIT_RSVD])
    else $error("reserved control bit took a write");
  a_brg_flag: assert property (@(posedge clk) disable iff (!rst_n)
    ovf[1] |=> uart_timer_control_status_ff[uart_timer_pkg::BIT_BRG_OVF])
    else $error("brg overflow flag not set");
  a_isr_clear: assert property (@(posedge clk) disable iff (!rst_n)
    isr_ack && !ovf[0] |=> !uart_timer_control_status_ff[uart_timer_pkg::BIT_GT_OVF])
    else $error("service acknowledge did not clear timer flag");

  // --------------------------------------------------------------------------
  // interrupt and serial engine outputs
  // --------------------------------------------------------------------------
  // only the general timer feeds the interrupt; brg overflows never do
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_ff <= uart_timer_pkg::RST_IRQ;
      irq_mask_ff <= uart_timer_pkg::RST_IRQ;
      brg_tick    <= 1'b0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~(stat_wr & wb_dat_i[0])) | ovf[0];
      irq_mask_ff <= mask_wr ? wb_dat_i[0] : irq_mask_ff;
      brg_tick    <= ovf[1];
    end
  end

  assign irq = irq_stat_ff & irq_mask_ff;

  a_gt_flag_irq: assert property (@(posedge clk) disable iff (!rst_n)
    ovf[0] |=> uart_timer_control_status_ff[uart_timer_pkg::BIT_GT_OVF] && irq_stat_ff
    && (irq == irq_mask_ff))
    else $error("timer overflow did not flag or interrupt");
  a_brg_no_irq: assert property (@(posedge clk) disable iff (!rst_n)
    !irq && !ovf[0] && !mask_wr |=> !irq)
    else $error("interrupt rose without a timer overflow");
  a_stat_w1c: assert property (@(posedge clk) disable iff (!rst_n)
    stat_wr && wb_dat_i[0] && !ovf[0] |=> !irq_stat_ff)
    else $error("status write of one did not clear interrupt");
  a_baud_tick: assert property (@(posedge clk) disable iff (!rst_n)
    ovf[1] |=> brg_tick ##1 (brg_tick == $past(ovf[1])))
    else $error("baud tick does not follow brg overflow");

endmodule // uart_timer_pair_control

`default_nettype wire

// *** bench/uart_serial_partner.sv ***
// serial engine and cpu stand-in at the far side of the timer pair
`timescale 1ns/10ps
`default_nettype none
module uart_serial_partner (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // from the timer block
  input  wire logic        brg_tick,
  input  wire logic        baud_double,
  // cpu side
  input  wire logic        ack_req,
  output logic             isr_ack,
  output logic      [15:0] tick_cnt,
  output logic      [15:0] half_cnt
);
  // bit clock derives from generator overflows, halved unless doubled
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt <= 16'h0000;
      half_cnt <= 16'h0000;
    end else if (brg_tick) begin
      tick_cnt <= tick_cnt + 16'h0001;
      half_cnt <= half_cnt + (baud_double ? 16'h0002 : 16'h0001);
    end
  end
  // service routine entry is a one-cycle pulse, as a cpu vector fetch
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) isr_ack <= 1'b0;
    else isr_ack <= ack_req;
  end
endmodule // uart_serial_partner
`default_nettype wire

// *** bench/uart_timer_pair_control_tb_top.sv ***
// self-checking bench for the uart timer pair control block
`timescale 1ns/10ps
`default_nettype none
module uart_timer_pair_control_tb_top;
  typedef struct {logic brg; logic [7:0] mode; logic [15:0] pre; logic [15:0] cnt;} row_t;
  logic        clk = 1'b0, resetn = 1'b0, cyc = 1'b0, stb = 1'b0, we_r = 1'b0, ack_req = 1'b0;
  logic [7:0]  adr_r = 8'h00, cnt_ofs;
  logic [3:0]  sel_r = 4'h0;
  logic [31:0] dat_r = 32'h0, wb_dat_o, rdv;
  logic        wb_ack_o, isr_ack, irq, baud_double, brg_tick;
  logic [15:0] tick_cnt, half_cnt;
  int          error_cnt = 0, checks_done = 0, n, k;
  // gate and count-select stay zero in every mode value
  row_t rows [8] = '{
    '{1'b0, 8'h00, 16'hFFFF, 16'h00E0}, '{1'b0, 8'h01, 16'hFFFF, 16'h0000},
    '{1'b0, 8'h02, 16'h40FF, 16'h4040}, '{1'b0, 8'h03, 16'h40FF, 16'h4100},
    '{1'b1, 8'h00, 16'hFFFF, 16'h00E0}, '{1'b1, 8'h10, 16'hFFFF, 16'h0000},
    '{1'b1, 8'h20, 16'h40FF, 16'h4040}, '{1'b1, 8'h30, 16'h40FF, 16'h4100}};
  uart_timer_pair_control i_dut (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we_r),
    .wb_adr_i(adr_r), .wb_sel_i(sel_r), .wb_dat_i(dat_r), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .isr_ack(isr_ack), .irq(irq), .baud_double(baud_double), .brg_tick(brg_tick));
  uart_serial_partner i_partner (.clk(clk), .resetn(resetn), .brg_tick(brg_tick), .baud_double(baud_double),
    .ack_req(ack_req), .isr_ack(isr_ack), .tick_cnt(tick_cnt), .half_cnt(half_cnt));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] dat);
    int i;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we_r <= we; adr_r <= adr; sel_r <= sel; dat_r <= dat;
    // ack is looked at on rising edges only; data is taken and the request dropped at that edge
    for (i = 0; i < 20 && wb_ack_o !== 1'b1; i++) @(posedge clk);
    rdv = wb_dat_o;
    cyc <= 1'b0; stb <= 1'b0; we_r <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      chk(32'h0, 32'h1);
      end_sim();
    end
    // callers compare outputs once the committing edge has settled
    @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] adr, input logic [15:0] dat);
    wb(1'b1, adr, 4'h3, {16'h0, dat});
  endtask
  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 4'hF, 32'h0);
    chk(rdv, exp);
  endtask
  // counts cycles until the overflow shows on brg_tick or irq
  task automatic wait_evt(input logic brg, input int lim);
    for (n = 0; n < lim && (brg ? brg_tick : irq) !== 1'b1; n++) @(negedge clk);
    if (n == lim) begin
      chk(32'h0, 32'h2);
      end_sim();
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    rd(uart_timer_pkg::OFS_CTRL, 32'h0);
    rd(uart_timer_pkg::OFS_MODE, 32'h0);
    chk({30'h0, irq, baud_double}, 32'h0);
    $display("test reset done");
    wr(uart_timer_pkg::OFS_IRQ_MASK, 16'h0001);
    // clk/12 keeps the stop write ahead of the next tick after overflow
    for (k = 0; k < 8; k++) begin
      cnt_ofs = rows[k].brg ? uart_timer_pkg::OFS_BRG_CNT : uart_timer_pkg::OFS_GT_CNT;
      wr(uart_timer_pkg::OFS_IRQ_STAT, 16'h0001);
      wr(uart_timer_pkg::OFS_MODE, {8'h00, rows[k].mode});
      wr(cnt_ofs, rows[k].pre);
      wr(uart_timer_pkg::OFS_CTRL, rows[k].brg ? 16'h0002 : 16'h0001);
      wait_evt(rows[k].brg, 60);
      if (rows[k].brg) chk({31'h0, irq}, 32'h0);
      rd(uart_timer_pkg::OFS_CTRL, rows[k].brg ? 32'h0A : 32'h05);
      wr(uart_timer_pkg::OFS_CTRL, 16'h0000);
      rd(cnt_ofs, {16'h0, rows[k].cnt});
    end
    $display("test modes done");
    repeat (30) @(posedge clk);
    rd(uart_timer_pkg::OFS_BRG_CNT, 32'h4100);
    chk({16'h0, tick_cnt}, 32'h4);
    chk({16'h0, half_cnt}, 32'h4);
    $display("test hold done");
    wr(uart_timer_pkg::OFS_CTRL, 16'h00C0);
    rd(uart_timer_pkg::OFS_CTRL, 32'h80);
    chk({31'h0, baud_double}, 32'h1);
    wr(uart_timer_pkg::OFS_CTRL, 16'h0000);
    $display("test reserved done");
    // undivided clock: sixteen ticks to overflow, twelve times sooner; generator
    // first so that the timer's interrupt is still pending afterwards
    for (k = 0; k < 2; k++) begin
      wr(uart_timer_pkg::OFS_IRQ_STAT, 16'h0001);
      wr(uart_timer_pkg::OFS_MODE, 16'h0011);
      wr(k ? uart_timer_pkg::OFS_GT_CNT : uart_timer_pkg::OFS_BRG_CNT, 16'hFFF0);
      wr(uart_timer_pkg::OFS_CTRL, k ? 16'h0011 : 16'h00A2);
      wait_evt(k == 0, 40);
      chk({31'h0, n == 16}, 32'h1);
      wr(uart_timer_pkg::OFS_CTRL, 16'h0000);
    end
    $display("test clock select done");
    chk({31'h0, irq}, 32'h1);
    wr(uart_timer_pkg::OFS_IRQ_MASK, 16'h0000);
    chk({31'h0, irq}, 32'h0);
    wr(uart_timer_pkg::OFS_IRQ_MASK, 16'h0001);
    chk({31'h0, irq}, 32'h1);
    wr(uart_timer_pkg::OFS_IRQ_STAT, 16'h0001);
    chk({31'h0, irq}, 32'h0);
    wr(uart_timer_pkg::OFS_CTRL, 16'h0004);
    @(posedge clk);
    ack_req <= 1'b1;
    @(posedge clk);
    ack_req <= 1'b0;
    rd(uart_timer_pkg::OFS_CTRL, 32'h0);
    rd(uart_timer_pkg::OFS_IRQ_STAT, 32'h0);
    chk({16'h0, tick_cnt}, 32'h5);
    chk({16'h0, half_cnt}, 32'h6);
    $display("test interrupt done");
    // reset in mid-run while the timer counts on the fast clock
    wr(uart_timer_pkg::OFS_CTRL, 16'h0091);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    rd(uart_timer_pkg::OFS_CTRL, 32'h0);
    rd(uart_timer_pkg::OFS_GT_CNT, 32'h0);
    chk({30'h0, irq, baud_double}, 32'h0);
    $display("test mid-run reset done");
    end_sim();
  end
endmodule // uart_timer_pair_control_tb_top
`default_nettype wire
